// [design/wmc_map.svh]
// Purpose: Split points, packing shift and reset value for the composer
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef WMC_MAP_SVH
`define WMC_MAP_SVH

// Lower unsigned slice width of the 22-bit operand
`define WMC_SPLIT22   4
// Lower unsigned slice width of each 35-bit operand
`define WMC_SPLIT35   17
// Bit position of the upper value in the packed squaring operand
`define WMC_PACK_N    12
// Rounding constant, half a unit at bit 2n
`define WMC_PACK_RND  36'h0_0080_0000
// Product register reset and clear value
`define WMC_PROD_RST  '0

`endif

// [design/wmc_pkg.sv]
// Purpose: Operand, product and state types of the wide multiplier composer
// Assumes: Fields are plain vectors; signedness is applied where used
// Notes:   Signed fields are two's complement
package wmc_pkg;

  // Operands from the surrounding fabric, one group per product
  typedef struct packed {
    logic [17:0] a18;
    logic [17:0] b18;
    logic [7:0]  a8u;
    logic [7:0]  b8u;
    logic [15:0] a16;
    logic [15:0] b16;
    logic [21:0] a22;
    logic [15:0] b22;
    logic [34:0] a35;
    logic [34:0] b35;
    logic        uns34;
    logic [5:0]  sq_x;
    logic [4:0]  sq_y;
  } operands_t;

  // Registered products
  typedef struct packed {
    logic [35:0] p18;
    logic [15:0] p8u;
    logic [31:0] p16;
    logic [37:0] p22;
    logic [69:0] p35;
    logic [10:0] sq_x;
    logic [9:0]  sq_y;
  } products_t;

  // Whole state of the composer
  typedef struct packed {
    products_t prod;
    logic      valid;
  } state_t;

endpackage

// [design/wide_multiplier_composer.sv]
// Purpose: Wide and packed products built from 18x18 product blocks
// Assumes: Operands come from logic on the same clock
// Notes:   All products register together under one load enable
//          Packed squaring fits only 6-bit signed X and 5-bit
//          unsigned Y at shift 12; wider values overlap
//          Clear has reset's priority and beats load
//          Product blocks are modelled by signed 18x18 multiplies
//          Reference products feed only the checks at the end
//          Unused result bits of narrow forms are dropped
//
// Behaviour
// - Product block gives 36-bit signed 18x18 product
// - Registered products load on enable, clear synchronously
// - Unused product block operand bits tied zero, sign-extended for signed narrow operands
// - Narrow products use a subset of bits
// - Wide operand splits: signed top, unsigned low
// - 22-bit operand splits 18 signed, 4 unsigned
// - Partial products are 20 and 34 bits
// - 38-bit result, low 4 bits bypass adder
// - Sign-extend 20-bit partial before adding
// - The 22x16 recombination adder is 34 bits
// - Low product concatenated below high, crosses added
// - 35x35 signed uses four blocks, two adders
// - Fixed adder 53 bits, 17 zero LSBs
// - 34x34 unsigned ties operand MSBs to zero
// - Packed operand is upper times 2^n plus lower
// - Zero halves leave the other square alone
// - Packing only where terms never overlap
// - Packed size pairs follow the allowed table
// - Square 6-bit signed and 5-bit unsigned together
`timescale 1ns/1ps
`include "wmc_map.svh"

module wide_multiplier_composer (
  // Clock and reset
  input  wire logic                CORE_CLK_I,
  input  wire logic                RESET_I,
  // Product register control
  input  wire logic                LOAD_EN_I,
  input  wire logic                SYNC_CLR_I,
  // Operands
  input  wire wmc_pkg::operands_t  OPERANDS_I,
  // Products
  output      wmc_pkg::products_t  PRODUCTS_O,
  output      logic                VALID_O
);

  ////////////////////////////////////////////////////////////////////////
  // One embedded product block, 18x18 signed to 36 bits

  function automatic logic [35:0] emb(input logic [17:0] a,
                                      input logic [17:0] b);
    logic signed [35:0] ea;
    logic signed [35:0] eb;
    ea  = {{18{a[17]}}, a};
    eb  = {{18{b[17]}}, b};
    emb = ea * eb;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and partial products

  wmc_pkg::state_t    state_reg;
  wmc_pkg::state_t    state_next;
  wmc_pkg::products_t comp;

  logic [17:0] b22_ext;
  logic [35:0] pp22_lo;
  logic [35:0] pp22_hi;
  logic [33:0] sum22;
  logic [34:0] ax;
  logic [34:0] bx;
  logic [35:0] hh;
  logic [35:0] ll;
  logic [35:0] c1;
  logic [35:0] c2;
  logic [36:0] csum;
  logic [52:0] fsum;
  logic [17:0] pk_op;
  logic [35:0] pk_p;
  logic [35:0] pk_r;
  logic [35:0] p8_full;
  logic [35:0] p16_full;

  ////////////////////////////////////////////////////////////////////////
  // Compose every product and the next state

  always_comb begin
    comp = '0;
    // Plain 18x18 signed product
    comp.p18 = emb(OPERANDS_I.a18, OPERANDS_I.b18);

    // Narrow unsigned: spare high operand bits held at zero
    p8_full  = emb({10'h0, OPERANDS_I.a8u},
                   {10'h0, OPERANDS_I.b8u});
    comp.p8u = p8_full[15:0];
    // Narrow signed 16x16, low 32 result bits only
    p16_full = emb({{2{OPERANDS_I.a16[15]}}, OPERANDS_I.a16},
                   {{2{OPERANDS_I.b16[15]}}, OPERANDS_I.b16});
    comp.p16 = p16_full[31:0];

    // 22x16: split at bit 4, low slice unsigned
    // b22 widened to the block's 18-bit input
    b22_ext = {{2{OPERANDS_I.b22[15]}}, OPERANDS_I.b22};
    pp22_lo = emb(b22_ext,
                  {14'h0, OPERANDS_I.a22[`WMC_SPLIT22-1:0]});
    pp22_hi = emb(b22_ext,
                  OPERANDS_I.a22[21:`WMC_SPLIT22]);
    // 20-bit partial sign-extended into the 34-bit adder
    // Zero fill here would turn a negative partial positive
    sum22 = pp22_hi[33:0]
          + {{18{pp22_lo[19]}}, pp22_lo[19:4]};
    // Low four bits skip the adder
    comp.p22 = {sum22, pp22_lo[3:0]};

    // 35x35 signed, or 34x34 unsigned with top bits tied low
    // Operand bit 34 is ignored in unsigned mode
    ax = OPERANDS_I.uns34 ? {1'b0, OPERANDS_I.a35[33:0]}
                          : OPERANDS_I.a35;
    bx = OPERANDS_I.uns34 ? {1'b0, OPERANDS_I.b35[33:0]}
                          : OPERANDS_I.b35;
    // Four blocks: high x high, low x low and two crosses
    hh = emb(ax[34:`WMC_SPLIT35], bx[34:`WMC_SPLIT35]);
    ll = emb({1'b0, ax[`WMC_SPLIT35-1:0]},
             {1'b0, bx[`WMC_SPLIT35-1:0]});
    c1 = emb(ax[34:`WMC_SPLIT35], {1'b0, bx[`WMC_SPLIT35-1:0]});
    c2 = emb({1'b0, ax[`WMC_SPLIT35-1:0]}, bx[34:`WMC_SPLIT35]);
    // First adder: crosses plus the upper half of low x low
    // Folding ll in here keeps the fixed adder at 53 bits
    csum = {c1[35], c1} + {c2[35], c2}
         + {20'h0, ll[33:`WMC_SPLIT35]};
    // Fixed adder: high x high carries 17 zero LSBs
    fsum = {hh, 17'h0}
         + {{16{csum[36]}}, csum};
    comp.p35 = {fsum, ll[`WMC_SPLIT35-1:0]};

    // Packed squaring: X at bit 12, Y in the low bits
    // Wider X or Y would let the three terms overlap
    pk_op = {OPERANDS_I.sq_x, 7'h0, OPERANDS_I.sq_y};
    pk_p  = emb(pk_op, pk_op);
    // Cross term is a multiple of 2^13, so low bits hold Y squared
    comp.sq_y = pk_p[9:0];
    // Rounding absorbs a signed cross term below 2^23
    pk_r = pk_p + `WMC_PACK_RND;
    comp.sq_x = pk_r[34:24];

    // Clear wins over load; otherwise hold
    // Clear acts like the block reset, so it outranks load
    state_next = state_reg;
    if (SYNC_CLR_I) begin
      state_next.prod  = `WMC_PROD_RST;
      state_next.valid = 1'b0;
    end else if (LOAD_EN_I) begin
      state_next.prod  = comp;
      state_next.valid = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, clocked every rising edge

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the register
  assign PRODUCTS_O = state_reg.prod;
  assign VALID_O    = state_reg.valid;

  ////////////////////////////////////////////////////////////////////////
  // Reference products, read only by the checks below

  logic signed [35:0] ref18;
  logic        [15:0] ref8;
  logic signed [31:0] ref16;
  logic signed [37:0] ref22;
  logic signed [69:0] ref35;
  logic        [67:0] ref34;
  logic        [10:0] refsx;
  logic        [9:0]  refsy;
  logic               load;

  // Full-width arithmetic, independent of the slicing
  assign ref18 = $signed(OPERANDS_I.a18) * $signed(OPERANDS_I.b18);
  assign ref8  = OPERANDS_I.a8u * OPERANDS_I.b8u;
  assign ref16 = $signed(OPERANDS_I.a16) * $signed(OPERANDS_I.b16);
  assign ref22 = $signed(OPERANDS_I.a22) * $signed(OPERANDS_I.b22);
  assign ref35 = $signed(OPERANDS_I.a35) * $signed(OPERANDS_I.b35);
  assign ref34 = OPERANDS_I.a35[33:0] * OPERANDS_I.b35[33:0];
  assign refsx = $signed(OPERANDS_I.sq_x) * $signed(OPERANDS_I.sq_x);
  assign refsy = OPERANDS_I.sq_y * OPERANDS_I.sq_y;
  assign load  = LOAD_EN_I && !SYNC_CLR_I;

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  // Plain block product
  prod18_a: assert property (
    load |=> $signed(PRODUCTS_O.p18) == $past(ref18))
    else $error("18x18 product wrong");

  // Enable and clear low two cycles running hold every product at the next edge
  hold_en_a: assert property (
    !LOAD_EN_I && !SYNC_CLR_I ##1 !LOAD_EN_I && !SYNC_CLR_I
    |=> $stable(PRODUCTS_O) && $stable(VALID_O))
    else $error("products moved without enable");

  // Synchronous clear empties the register even with enable
  sync_clr_a: assert property (
    SYNC_CLR_I |=> PRODUCTS_O == '0 && !VALID_O)
    else $error("clear did not empty products");

  // Narrow products
  narrow_prod_a: assert property (
    load |=> PRODUCTS_O.p8u == $past(ref8)
         && $signed(PRODUCTS_O.p16) == $past(ref16))
    else $error("narrow product wrong");

  // 22x16 composition
  prod22_a: assert property (
    load |=> $signed(PRODUCTS_O.p22) == $past(ref22))
    else $error("22x16 product wrong");

  // 35x35 signed composition
  prod35_a: assert property (
    load && !OPERANDS_I.uns34
    |=> $signed(PRODUCTS_O.p35) == $past(ref35))
    else $error("35x35 product wrong");

  // 34x34 unsigned composition, top bits zero
  prod34_a: assert property (
    load && OPERANDS_I.uns34
    |=> PRODUCTS_O.p35 == {2'h0, $past(ref34)})
    else $error("34x34 product wrong");

  // Both packed squares recovered
  packed_sq_a: assert property (
    load |=> PRODUCTS_O.sq_x == $past(refsx)
         && PRODUCTS_O.sq_y == $past(refsy))
    else $error("packed squares wrong");

  // Valid follows the load and holds two cycles while no clear arrives
  valid_flag_a: assert property (
    load ##1 !SYNC_CLR_I [*2] |-> VALID_O ##1 VALID_O)
    else $error("valid lost after load");

  ////////////////////////////////////////////////////////////////////////
  // Checks on valid, slices, partials, adders and packing

  // A taken load always raises valid
  valid_set_a: assert property (
    load |=> VALID_O)
    else $error("valid not raised by load");

  // Low four result bits come from the first partial alone
  low_bypass_a: assert property (
    load |=> PRODUCTS_O.p22[3:0] == $past(ref22[3:0]))
    else $error("22x16 low bits wrong");

  // Lower slice of a22 multiplies as an unsigned value
  low_slice_a: assert property (
    $signed(pp22_lo) == $signed(OPERANDS_I.b22)
      * $signed({1'b0, OPERANDS_I.a22[`WMC_SPLIT22-1:0]}))
    else $error("22x16 low slice product wrong");

  // Partials fit 20 and 34 signed bits
  partial_width_a: assert property (
    pp22_lo[35:19] == {17{pp22_lo[19]}}
    && pp22_hi[35:33] == {3{pp22_hi[33]}})
    else $error("22x16 partial product too wide");

  // The 34-bit adder alone gives the upper result bits
  adder22_a: assert property (
    sum22 == ref22[37:4])
    else $error("22x16 adder sum wrong");

  // Top 18 bits of each operand multiply as signed slices
  high_slice_a: assert property (
    $signed(hh) == $signed(ax[34:`WMC_SPLIT35])
                   * $signed(bx[34:`WMC_SPLIT35]))
    else $error("high by high product wrong");

  // First cross: signed high a by unsigned low b
  cross_one_a: assert property (
    $signed(c1) == $signed(ax[34:`WMC_SPLIT35])
                   * $signed({1'b0, bx[`WMC_SPLIT35-1:0]}))
    else $error("first cross product wrong");

  // Second cross: unsigned low a by signed high b
  cross_two_a: assert property (
    $signed(c2) == $signed({1'b0, ax[`WMC_SPLIT35-1:0]})
                   * $signed(bx[34:`WMC_SPLIT35]))
    else $error("second cross product wrong");

  // Unsigned mode keeps both operand sign bits low
  msb_tie_a: assert property (
    OPERANDS_I.uns34 |-> !ax[34] && !bx[34])
    else $error("unsigned operand top bit not low");

  // Low by low is unsigned and fills only 34 bits
  low_unsigned_a: assert property (
    ll[35:34] == 2'h0)
    else $error("low by low product not unsigned");

  // Zero LSBs on the high input leave the low bits uncarried
  fixed_adder_a: assert property (
    fsum[16:0] == csum[16:0])
    else $error("fixed adder low bits wrong");

  // Narrow forms never reach the unused result bits
  narrow_top_a: assert property (
    p8_full[35:16] == 20'h0
    && p16_full[35:31] == {5{p16_full[31]}})
    else $error("narrow product spills upward");

  // Packed operand is X times 2^12 plus Y
  pack_split_a: assert property (
    $signed(pk_op) == $signed(OPERANDS_I.sq_x)
                      * (18'sh00001 <<< `WMC_PACK_N)
                      + $signed({1'b0, OPERANDS_I.sq_y}))
    else $error("packed operand wrong");

  // Zero Y leaves X squared alone in the high bits
  pack_zero_y_a: assert property (
    OPERANDS_I.sq_y == 5'h00 |-> pk_p == {1'b0, refsx, 24'h000000})
    else $error("upper square not alone");

  // Zero X leaves Y squared alone in the low bits
  pack_zero_x_a: assert property (
    OPERANDS_I.sq_x == 6'h00 |-> pk_p == {26'h0, refsy})
    else $error("lower square not alone");

  // Gap between Y squared and the cross term stays empty
  pack_gap_a: assert property (
    pk_p[12:10] == 3'h0)
    else $error("packed terms overlap");

endmodule

// [tb/operand_source.sv]
// Purpose: Fabric stage that feeds operands to the composer
// Assumes: Same clock and reset as the composer
// Notes:   One register stage, like fabric cells beside the block
`timescale 1ns/1ps
module operand_source (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Operands and load request from the bench
  input  wire wmc_pkg::operands_t ops_i,
  input  wire logic               load_i,
  // Registered operands towards the composer
  output      wmc_pkg::operands_t ops_o,
  output      logic               load_o
);
  // Register next to the block keeps the operand path short
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ops_o  <= '0;
      load_o <= 1'b0;
    end else begin
      ops_o  <= ops_i;
      load_o <= load_i;
    end
  end
endmodule

// [tb/test_wide_multiplier_composer.sv]
// Purpose: Self-checking bench for the wide multiplier composer
// Assumes: Operands pass one fabric register before the composer
// Notes:   Expected products come from plain full-width arithmetic
`timescale 1ns/1ps
module test_wide_multiplier_composer;
  logic               core_clk;
  logic               reset;
  logic               sync_clr;
  logic               src_ld;
  logic               load_en;
  wmc_pkg::operands_t src_ops;
  wmc_pkg::operands_t ops;
  wmc_pkg::products_t prod;
  logic               valid;
  int                 num_errors;
  int                 checks_done;

  ////////////////////////////////////////////////////////////////////////
  // Partner fabric and composer
  operand_source i_operand_source (.clk_i(core_clk), .rst_i(reset),
    .ops_i(src_ops), .load_i(src_ld), .ops_o(ops), .load_o(load_en));
  wide_multiplier_composer i_wide_multiplier_composer (
    .CORE_CLK_I(core_clk), .RESET_I(reset), .LOAD_EN_I(load_en),
    .SYNC_CLR_I(sync_clr), .OPERANDS_I(ops), .PRODUCTS_O(prod),
    .VALID_O(valid));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [69:0] seen,
                       input logic [69:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Exact products; wide signed context avoids truncated partials
  function automatic wmc_pkg::products_t exp_of(
    input wmc_pkg::operands_t o);
    wmc_pkg::products_t e;
    e.p18  = $signed(o.a18) * $signed(o.b18);
    e.p8u  = o.a8u * o.b8u;
    e.p16  = $signed(o.a16) * $signed(o.b16);
    e.p22  = $signed(o.a22) * $signed(o.b22);
    e.p35  = $signed(o.a35) * $signed(o.b35);
    if (o.uns34) begin
      e.p35 = o.a35[33:0] * o.b35[33:0];
    end
    e.sq_x = $signed(o.sq_x) * $signed(o.sq_x);
    e.sq_y = o.sq_y * o.sq_y;
    return e;
  endfunction

  task automatic expect_all(input wmc_pkg::products_t e, input logic v);
    check("p18", prod.p18, e.p18);
    check("p8u", prod.p8u, e.p8u);
    check("p16", prod.p16, e.p16);
    check("p22", prod.p22, e.p22);
    check("p22_lo", prod.p22[3:0], e.p22[3:0]);
    check("p35", prod.p35, e.p35);
    check("sq_x", prod.sq_x, e.sq_x);
    check("sq_y", prod.sq_y, e.sq_y);
    check("valid", valid, v);
  endtask

  // Drive just after the edge, never on it
  task automatic drive(input wmc_pkg::operands_t o, input logic ld);
    @(posedge core_clk);
    #1;
    src_ops = o;
    src_ld  = ld;
  endtask

  // Back-to-back loads, then a hold with fresh operands present
  task automatic pair(input wmc_pkg::operands_t a,
                      input wmc_pkg::operands_t b);
    drive(a, 1'b1);
    drive(b, 1'b1);
    drive(b, 1'b0);
    expect_all(exp_of(a), 1'b1);
    drive(b, 1'b0);
    expect_all(exp_of(b), 1'b1);
    drive(a, 1'b0);
    drive(a, 1'b0);
    drive(a, 1'b0);
    expect_all(exp_of(b), 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    expect_all('0, 1'b0);
  endtask

  // Most negative operands, then their complements in unsigned mode
  task automatic t_corners();
    wmc_pkg::operands_t a;
    a = '{18'h20000, 18'h20000, 8'hff, 8'hfe, 16'h8000, 16'h8000,
          22'h200000, 16'h8000, 35'h400000000, 35'h400000000, 1'b0,
          6'h20, 5'h00};
    pair(a, ~a);
  endtask

  // Near-full low slices of a35 and b35 stress the carry into the upper partials
  task automatic t_mixed();
    wmc_pkg::operands_t a;
    a = '{18'h1ffff, 18'h20001, 8'hff, 8'hff, 16'h7fff, 16'h8001,
          22'h3ffff5, 16'h7abc, 35'h2aaaaffff, 35'h45555fffe, 1'b0,
          6'h00, 5'h13};
    pair(a, ~a);
  endtask

  // All-zero load, then clear winning over a load at the same edge
  task automatic t_clear();
    pair('0, '0);
    t_mixed();
    drive(~src_ops, 1'b1);
    drive(src_ops, 1'b0);
    sync_clr = 1'b1;
    drive(src_ops, 1'b0);
    sync_clr = 1'b0;
    expect_all('0, 1'b0);
  endtask

  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, sequence and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    num_errors  = 0;
    checks_done = 0;
    reset       = 1'b1;
    sync_clr    = 1'b0;
    src_ld      = 1'b0;
    src_ops     = '0;
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_corners();
    t_mixed();
    t_clear();
    final_report();
  end

  // Run needs under 100 cycles; far beyond that means a hang
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule
